/* core/ecf_frame_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ecf_defs.svh"

module ecf_frame_fifo (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // mac receive client
  input wire logic [7:0] rx_data,
  input wire logic rx_data_valid,
  input wire logic rx_good_frame,
  input wire logic rx_bad_frame,
  output logic rx_overflow,
  // user receive stream
  output logic [7:0] rx_usr_data,
  output logic rx_usr_sof_n,
  output logic rx_usr_eof_n,
  output logic rx_usr_src_rdy_n,
  input wire logic rx_usr_dst_rdy_n,
  output logic [3:0] rx_fifo_status,
  input wire logic swap_en,
  // user transmit stream
  input wire logic [7:0] tx_usr_data,
  input wire logic tx_usr_sof_n,
  input wire logic tx_usr_eof_n,
  input wire logic tx_usr_src_rdy_n,
  output logic tx_usr_dst_rdy_n,
  output logic [3:0] tx_fifo_status,
  // mac transmit client
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  input wire logic tx_ack,
  input wire logic tx_collision,
  input wire logic tx_retransmit,
  output logic tx_overflow
);
  import ecf_pkg::*;

  ecf_state_t s_q;
  ecf_state_t s_d;
  logic [7:0] rx_mem [`ECF_BUF_BYTES];
  logic rx_eof_mem [`ECF_BUF_BYTES];
  logic [7:0] tx_mem [`ECF_BUF_BYTES];
  logic tx_eof_mem [`ECF_BUF_BYTES];
  logic [7:0] tx_rdata_q;
  logic rx_we;
  logic rx_eof_set;
  logic tx_we;
  logic tx_xfer;
  logic rx_take;
  logic rx_eof_now;
  logic tx_eof_now;
  ecf_ptr_t rx_fill;
  ecf_ptr_t tx_fill;
  ecf_ptr_t rx_fill_d;
  ecf_ptr_t tx_fill_d;
  ecf_ptr_t rx_lin;
  ecf_ptr_t rx_map;
  ecf_ptr_t rx_eof_addr;
  ecf_ptr_t tx_raddr;
  ecf_ptr_t tx_lin;

  ecf_stream_if #(.W(`ECF_QUEUE_W)) q_in ();
  ecf_stream_if #(.W(`ECF_QUEUE_W)) q_out ();

  // short frames of under twelve bytes are not swapped correctly
  function automatic ecf_ptr_t swap_off(input ecf_ptr_t k, input logic en);
    ecf_ptr_t r;
    r = k;
    if (en && k < `ECF_MAC_LEN) begin
      r = k + `ECF_MAC_LEN;
    end else if (en && k < `ECF_SWAP_LEN) begin
      r = k - `ECF_MAC_LEN;
    end
    return r;
  endfunction

  function automatic logic [3:0] occupancy(input ecf_ptr_t fill);
    logic [3:0] r;
    r = fill[`ECF_STAT_MSB:`ECF_STAT_LSB];
    if (fill == `ECF_BUF_BYTES) begin
      r = `ECF_STAT_FULL;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // receive write side
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rx_ovf = 1'b0;
    s_d.tx_ovf = 1'b0;
    rx_we = 1'b0;
    rx_eof_set = 1'b0;
    rx_fill = s_q.rx_wr - s_q.rx_base;
    if (rx_good_frame || rx_bad_frame) begin
      if (s_q.rx_drop || rx_bad_frame) begin
        s_d.rx_wr = s_q.rx_commit;
      end else begin
        s_d.rx_commit = s_q.rx_wr;
        rx_eof_set = 1'b1;
      end
      s_d.rx_drop = 1'b0;
    end else if (rx_data_valid && !s_q.rx_drop) begin
      if (rx_fill == `ECF_BUF_BYTES) begin
        s_d.rx_drop = 1'b1;
        s_d.rx_ovf = 1'b1;
      end else begin
        rx_we = 1'b1;
        s_d.rx_wr = s_q.rx_wr + 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // receive read side with address swap by read order
    // ----------------------------------------------------------------
    rx_lin = s_q.rx_base + s_q.rx_off;
    rx_map = s_q.rx_base + swap_off(s_q.rx_off, swap_en);
    rx_eof_now = rx_eof_mem[rx_lin[`ECF_ADR_W-1:0]];
    q_in.valid = (s_q.rx_off < (s_q.rx_commit - s_q.rx_base));
    q_in.data = {(s_q.rx_off == '0), rx_eof_now, rx_mem[rx_map[`ECF_ADR_W-1:0]]};
    if (q_in.valid && q_in.ready) begin
      if (rx_eof_now) begin
        s_d.rx_base = rx_lin + 1'b1;
        s_d.rx_off = '0;
      end else begin
        s_d.rx_off = s_q.rx_off + 1'b1;
      end
    end
    rx_fill_d = s_d.rx_wr - s_d.rx_base;
    s_d.rx_stat = occupancy(rx_fill_d);

    // ----------------------------------------------------------------
    // receive user output register
    // ----------------------------------------------------------------
    rx_take = q_out.valid && (s_q.rx_usr_src_rdy_n || !rx_usr_dst_rdy_n);
    q_out.ready = s_q.rx_usr_src_rdy_n || !rx_usr_dst_rdy_n;
    if (rx_take) begin
      s_d.rx_usr_data = q_out.data[7:0];
      s_d.rx_usr_eof_n = !q_out.data[8];
      s_d.rx_usr_sof_n = !q_out.data[9];
      s_d.rx_usr_src_rdy_n = 1'b0;
    end else if (!rx_usr_dst_rdy_n) begin
      s_d.rx_usr_src_rdy_n = 1'b1;
    end

    // ----------------------------------------------------------------
    // transmit write side
    // ----------------------------------------------------------------
    tx_we = 1'b0;
    tx_xfer = !tx_usr_src_rdy_n && !s_q.tx_usr_dst_rdy_n;
    if (tx_xfer) begin
      if (s_q.tx_drop) begin
        if (!tx_usr_eof_n) begin
          s_d.tx_drop = 1'b0;
        end
      end else begin
        tx_we = 1'b1;
        s_d.tx_wr = s_q.tx_wr + 1'b1;
        if (!tx_usr_eof_n) begin
          s_d.tx_commit = s_q.tx_wr + 1'b1;
        end
      end
    end

    // ----------------------------------------------------------------
    // transmit mac side
    // ----------------------------------------------------------------
    tx_lin = s_q.tx_base + s_q.tx_off;
    tx_eof_now = tx_eof_mem[tx_lin[`ECF_ADR_W-1:0]];
    case (s_q.tx_st)
      ECF_TX_IDLE: begin
        if (s_q.tx_commit != s_q.tx_base) begin
          s_d.tx_off = '0;
          s_d.tx_valid = 1'b1;
          s_d.tx_st = ECF_TX_WAIT;
        end
      end
      ECF_TX_WAIT, ECF_TX_SEND: begin
        if (tx_collision || tx_retransmit) begin
          s_d.tx_valid = 1'b0;
          s_d.tx_off = '0;
          s_d.tx_st = tx_retransmit ? ECF_TX_IDLE : ECF_TX_DISC;
        end else if (tx_ack || s_q.tx_st == ECF_TX_SEND) begin
          if (tx_eof_now) begin
            s_d.tx_valid = 1'b0;
            s_d.tx_base = s_q.tx_base + s_q.tx_off + 1'b1;
            s_d.tx_off = '0;
            s_d.tx_st = ECF_TX_IDLE;
          end else begin
            s_d.tx_off = s_q.tx_off + 1'b1;
            s_d.tx_st = ECF_TX_SEND;
          end
        end
      end
      ECF_TX_DISC: begin
        if (tx_eof_now) begin
          s_d.tx_base = s_q.tx_base + s_q.tx_off + 1'b1;
          s_d.tx_off = '0;
          s_d.tx_st = ECF_TX_IDLE;
        end else begin
          s_d.tx_off = s_q.tx_off + 1'b1;
        end
      end
      default: begin
        s_d.tx_st = ECF_TX_IDLE;
        s_d.tx_valid = 1'b0;
      end
    endcase
    tx_raddr = s_d.tx_base + s_d.tx_off;

    // ----------------------------------------------------------------
    // transmit full and overflow
    // ----------------------------------------------------------------
    tx_fill = s_d.tx_wr - s_q.tx_base;
    if (tx_fill == `ECF_BUF_BYTES && s_d.tx_commit == s_q.tx_base && !s_d.tx_drop) begin
      s_d.tx_drop = 1'b1;
      s_d.tx_ovf = 1'b1;
      s_d.tx_wr = s_d.tx_commit;
    end
    tx_fill_d = s_d.tx_wr - s_d.tx_base;
    // ready is judged against the old base, so a freed byte shows a cycle late
    s_d.tx_usr_dst_rdy_n = !(s_d.tx_drop || (s_d.tx_wr - s_q.tx_base) < `ECF_BUF_BYTES);
    s_d.tx_stat = occupancy(tx_fill_d);
  end

  // ----------------------------------------------------------------
  // receive output queue
  // ----------------------------------------------------------------
  ecf_queue #(.W(`ECF_QUEUE_W), .D(`ECF_QUEUE_DEPTH)) u_queue (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_s(q_in),
    .rd_s(q_out)
  );

  // ----------------------------------------------------------------
  // frame memories
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rx_we) begin
      rx_mem[s_q.rx_wr[`ECF_ADR_W-1:0]] <= rx_data;
      rx_eof_mem[s_q.rx_wr[`ECF_ADR_W-1:0]] <= 1'b0;
    end
    if (rx_eof_set) begin
      rx_eof_mem[s_q.rx_wr[`ECF_ADR_W-1:0] - 1'b1] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (tx_we) begin
      tx_mem[s_q.tx_wr[`ECF_ADR_W-1:0]] <= tx_usr_data;
      tx_eof_mem[s_q.tx_wr[`ECF_ADR_W-1:0]] <= !tx_usr_eof_n;
    end
    tx_rdata_q <= tx_mem[tx_raddr[`ECF_ADR_W-1:0]];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
      s_q.rx_usr_sof_n <= 1'b1;
      s_q.rx_usr_eof_n <= 1'b1;
      s_q.rx_usr_src_rdy_n <= 1'b1;
      s_q.tx_usr_dst_rdy_n <= 1'b1;
      s_q.tx_st <= ECF_TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // start of frame is only an input marker; it is not needed to delimit
  logic unused_sof;
  assign unused_sof = tx_usr_sof_n;

  assign rx_overflow = s_q.rx_ovf;
  assign rx_usr_data = s_q.rx_usr_data;
  assign rx_usr_sof_n = s_q.rx_usr_sof_n;
  assign rx_usr_eof_n = s_q.rx_usr_eof_n;
  assign rx_usr_src_rdy_n = s_q.rx_usr_src_rdy_n;
  assign rx_fifo_status = s_q.rx_stat;
  assign tx_usr_dst_rdy_n = s_q.tx_usr_dst_rdy_n;
  assign tx_fifo_status = s_q.tx_stat;
  assign tx_data = tx_rdata_q;
  assign tx_data_valid = s_q.tx_valid;
  assign tx_overflow = s_q.tx_ovf;

endmodule

`default_nettype wire

/* shared/ecf_defs.svh */
// Summary of operation
// - each frame buffer holds 4096 bytes
// - good received frames are offered to user
// - bad received frames are dropped entirely
// - receive overflow drops frame, raises overflow flag
// - transmit starts only after whole frame stored
// - first byte waits for ack, then rest
// - retransmit request requeues frame from start
// - transmit full drops user destination ready
// - full without complete frame: flag, accept, drop
// - swap destination and source address fields
// - controls delayed exactly like data bytes
// - user controls active low, both readies transfer
// - user side is 8-bit, synchronous reset
// - collision ends frame, requeue with retransmit
// - each buffer gives 4-bit occupancy status
`ifndef ECF_DEFS_SVH
`define ECF_DEFS_SVH

// ----------------------------------------------------------------
// buffer geometry
// ----------------------------------------------------------------
`define ECF_BUF_BYTES 13'h1000
`define ECF_PTR_W 13
`define ECF_ADR_W 12
`define ECF_DATA_W 8
`define ECF_JUMBO_LIMIT 4000

// ----------------------------------------------------------------
// status and address swap
// ----------------------------------------------------------------
`define ECF_STAT_MSB 11
`define ECF_STAT_LSB 8
`define ECF_STAT_FULL 4'hf
`define ECF_MAC_LEN 13'h0006
`define ECF_SWAP_LEN 13'h000c

// ----------------------------------------------------------------
// receive output queue
// ----------------------------------------------------------------
`define ECF_QUEUE_DEPTH 16
`define ECF_QUEUE_W 10

`endif

/* shared/ecf_pkg.sv */
`include "ecf_defs.svh"

package ecf_pkg;

  typedef enum logic [3:0] {
    ECF_TX_IDLE = 4'h1,
    ECF_TX_WAIT = 4'h2,
    ECF_TX_SEND = 4'h4,
    ECF_TX_DISC = 4'h8
  } ecf_tx_st_t;

  typedef logic [`ECF_PTR_W-1:0] ecf_ptr_t;

  typedef struct packed {
    ecf_ptr_t rx_wr;
    ecf_ptr_t rx_commit;
    ecf_ptr_t rx_base;
    ecf_ptr_t rx_off;
    logic rx_drop;
    logic rx_ovf;
    logic [3:0] rx_stat;
    logic [7:0] rx_usr_data;
    logic rx_usr_sof_n;
    logic rx_usr_eof_n;
    logic rx_usr_src_rdy_n;
    ecf_ptr_t tx_wr;
    ecf_ptr_t tx_commit;
    ecf_ptr_t tx_base;
    ecf_ptr_t tx_off;
    logic tx_drop;
    logic tx_ovf;
    logic tx_usr_dst_rdy_n;
    logic [3:0] tx_stat;
    ecf_tx_st_t tx_st;
    logic tx_valid;
  } ecf_state_t;

endpackage

/* shared/ecf_stream_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface ecf_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic valid;
  logic ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

/* core/ecf_queue.sv */
`timescale 1ns/100ps
`default_nettype none

module ecf_queue #(
  parameter int W = 10,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // filling and draining sides
  ecf_stream_if.snk wr_s,
  ecf_stream_if.src rd_s
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ecf_queue_st_t;

  ecf_queue_st_t s_q;
  ecf_queue_st_t s_d;
  logic [W-1:0] mem [D];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // flags and handshakes
  // ----------------------------------------------------------------
  always_comb begin
    empty = (s_q.wp == s_q.rp);
    full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    push = wr_s.valid && !full;
    pop = rd_s.ready && !empty;
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
  end

  assign wr_s.ready = !full;
  assign rd_s.valid = !empty;
  assign rd_s.data = mem[s_q.rp[AW-1:0]];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[s_q.wp[AW-1:0]] <= wr_s.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

/* dv/ecf_frame_fifo_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module ecf_frame_fifo_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // receive side
  input wire logic rx_data_valid,
  input wire logic rx_overflow,
  input wire logic [7:0] rx_usr_data,
  input wire logic rx_usr_sof_n,
  input wire logic rx_usr_eof_n,
  input wire logic rx_usr_src_rdy_n,
  input wire logic rx_usr_dst_rdy_n,
  input wire logic [3:0] rx_fifo_status,
  // transmit side
  input wire logic tx_usr_dst_rdy_n,
  input wire logic [3:0] tx_fifo_status,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic tx_ack,
  input wire logic tx_collision,
  input wire logic tx_overflow
);
  logic acked_q, in_rx_q;
  // --------
  // frame tracking
  // --------
  always_ff @(posedge clk_sys) begin
    if (srst || !tx_data_valid) acked_q <= 1'b0;
    else if (tx_ack) acked_q <= 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) in_rx_q <= 1'b0;
    else if (!rx_usr_src_rdy_n && !rx_usr_dst_rdy_n) in_rx_q <= rx_usr_eof_n;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_stall;
    !rx_usr_src_rdy_n && rx_usr_dst_rdy_n;
  endsequence
  sequence s_abort;
    tx_collision && tx_data_valid;
  endsequence
  // --------
  // checks
  // --------
  reset_idle_a:
    assert property (disable iff (1'b0) srst |=> !tx_data_valid && rx_usr_src_rdy_n &&
      tx_usr_dst_rdy_n && !rx_overflow && !tx_overflow && rx_fifo_status == 4'h0 &&
      tx_fifo_status == 4'h0) else $error("outputs not idle after reset");
  rx_hold_a:
    assert property (s_stall |=> !rx_usr_src_rdy_n && $stable(rx_usr_data) &&
      $stable(rx_usr_sof_n) && $stable(rx_usr_eof_n)) else $error("byte not held");
  rx_sof_a:
    assert property (!rx_usr_src_rdy_n |-> rx_usr_sof_n == in_rx_q)
    else $error("start mark wrong");
  rx_ovf_a:
    assert property (rx_overflow |-> $past(rx_data_valid) ##1 !rx_overflow)
    else $error("receive overflow pulse wrong");
  tx_ovf_a:
    assert property (tx_overflow |=> !tx_overflow ##[0:3] !tx_usr_dst_rdy_n)
    else $error("transmit overflow stalls user");
  tx_full_a:
    assert property ($rose(tx_usr_dst_rdy_n) && !$past(srst) |-> ##[0:2] tx_fifo_status == 4'hf)
    else $error("stall while not full");
  tx_wait_a:
    assert property (tx_data_valid && $past(tx_data_valid) && !acked_q |-> $stable(tx_data))
    else $error("byte moved before ack");
  tx_abort_a:
    assert property (s_abort |=> !tx_data_valid) else $error("frame not ended");
endmodule
bind ecf_frame_fifo ecf_frame_fifo_asserts u_chk (.*);
`default_nettype wire

/* dv/ecf_mac_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ecf_mac_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // transmit client
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  output logic tx_ack,
  output logic tx_collision,
  output logic tx_retransmit,
  // bench controls: ack wait (4'hf never), abort kind
  input wire logic [3:0] ack_dly,
  input wire logic [1:0] kill
);
  logic [1:0] st = 2'd0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] cur[$];
  logic [7:0] got[$];
  // --------
  // frame sink
  // --------
  always @(posedge clk_sys) begin
    {tx_ack, tx_collision, tx_retransmit} <= 3'b000;
    if (srst || !tx_data_valid) begin
      // only a frame that ran to its end counts as sent
      if (st == 2'd1) got = {got, cur};
      cur.delete();
      st <= 2'd0;
      cnt <= 4'h0;
    end else if (st == 2'd0) begin
      if (cnt == ack_dly && ack_dly != 4'hf) begin
        tx_ack <= 1'b1;
        st <= 2'd1;
      end else cnt <= cnt + 4'h1;
    end else if (st == 2'd1) begin
      cur.push_back(tx_data);
      if (kill != 2'd0 && cur.size() == 2) begin
        tx_collision <= 1'b1;
        tx_retransmit <= kill[0];
        st <= 2'd2;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_ethernet_client_frame_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_ethernet_client_frame_fifo;
  logic clk_sys = 1'b0, srst = 1'b1, swap_en = 1'b0, hold = 1'b1;
  logic [7:0] rx_data = 8'h00, tx_usr_data = 8'h00, rx_usr_data, tx_data;
  logic rx_data_valid = 1'b0, rx_good_frame = 1'b0, rx_bad_frame = 1'b0;
  logic rx_usr_dst_rdy_n = 1'b1, tx_usr_sof_n = 1'b1, tx_usr_eof_n = 1'b1;
  logic tx_usr_src_rdy_n = 1'b1, rxo = 1'b0, txo = 1'b0;
  logic [3:0] ack_dly = 4'h0, rx_fifo_status, tx_fifo_status;
  logic [1:0] kill = 2'h0;
  logic rx_overflow, rx_usr_sof_n, rx_usr_eof_n, rx_usr_src_rdy_n, tx_usr_dst_rdy_n;
  logic tx_data_valid, tx_ack, tx_collision, tx_retransmit, tx_overflow;
  int fails = 0, checks_done = 0, cyc = 0;
  logic [8:0] rx_exp[$], rx_got[$];
  logic [7:0] tx_exp[$];
  // length, good, swap, ack wait
  int rows[4][4] = '{'{20, 1, 0, 0}, '{14, 0, 0, 3}, '{16, 1, 1, 5}, '{60, 1, 1, 1}};
  ecf_frame_fifo u_dut (.*);
  ecf_mac_model u_mac (.*);
  initial forever #10 clk_sys = ~clk_sys;
  // --------
  // user side reader and watchdog
  // --------
  always @(negedge clk_sys) begin
    cyc++;
    // reader stalls every third cycle to exercise holding
    rx_usr_dst_rdy_n = hold || cyc % 3 == 0;
    // judged off the edge: the coming rising edge takes exactly these levels
    if (!srst && !rx_usr_src_rdy_n && !rx_usr_dst_rdy_n)
      rx_got.push_back({!rx_usr_eof_n, rx_usr_data});
    rxo |= rx_overflow;
    txo |= tx_overflow;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rx_frame(input int n, input logic good, input logic [7:0] b, input logic keep);
    for (int k = 0; k < n; k++) begin
      if (good && keep)
        rx_exp.push_back({k == n - 1, b + 8'(swap_en && k < 12 ? (k < 6 ? k + 6 : k - 6) : k)});
      rx_data = b + 8'(k);
      rx_data_valid = 1'b1;
      @(negedge clk_sys);
    end
    rx_data_valid = 1'b0;
    rx_good_frame = good;
    rx_bad_frame = !good;
    @(negedge clk_sys);
    rx_good_frame = 1'b0;
    rx_bad_frame = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic tx_frame(input int n, input logic [7:0] b, input logic keep);
    for (int k = 0; k < n; k++) begin
      if (keep) tx_exp.push_back(b + 8'(k));
      tx_usr_data = b + 8'(k);
      tx_usr_sof_n = k != 0;
      tx_usr_eof_n = k != n - 1;
      tx_usr_src_rdy_n = 1'b0;
      // ready only moves on rising edges, so its level here is what gets sampled
      while (tx_usr_dst_rdy_n) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    tx_usr_src_rdy_n = 1'b1;
    // one idle cycle so a following call never re-raises valid in this step
    @(negedge clk_sys);
  endtask
  task automatic drain();
    while (rx_got.size() < rx_exp.size() || u_mac.got.size() < tx_exp.size())
      @(negedge clk_sys);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic cmp(input string t);
    chk(16'(rx_got.size()), 16'(rx_exp.size()));
    chk(16'(u_mac.got.size()), 16'(tx_exp.size()));
    foreach (rx_exp[i]) chk(16'(rx_got[i]), 16'(rx_exp[i]));
    foreach (tx_exp[i]) chk(16'(u_mac.got[i]), 16'(tx_exp[i]));
    $display("test %s done", t);
  endtask
  // --------
  // sequence
  // --------
  initial begin
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk({rx_usr_src_rdy_n, rx_usr_sof_n, rx_usr_eof_n, tx_data_valid, rx_overflow,
      tx_overflow, rx_fifo_status, tx_fifo_status}, 16'h3800);
    @(negedge clk_sys);
    chk(tx_usr_dst_rdy_n, 1'b0);
    $display("test reset done");
    hold = 1'b0;
    foreach (rows[r]) begin
      swap_en = rows[r][2][0];
      ack_dly = 4'(rows[r][3]);
      rx_frame(rows[r][0], rows[r][1][0], 8'(r * 32), 1'b1);
      tx_frame(rows[r][0], 8'(r * 32 + 16), 1'b1);
      drain();
    end
    cmp("rows");
    hold = 1'b1;
    rx_frame(4000, 1'b1, 8'h11, 1'b1);
    chk(rx_fifo_status, 4'hf);
    rx_frame(200, 1'b1, 8'h22, 1'b0);
    chk(rxo, 1'b1);
    hold = 1'b0;
    drain();
    rx_frame(20, 1'b1, 8'h33, 1'b1);
    drain();
    cmp("rx overflow");
    kill = 2'd1;
    tx_frame(30, 8'h40, 1'b1);
    while (!tx_retransmit) @(negedge clk_sys);
    kill = 2'd0;
    drain();
    kill = 2'd2;
    tx_frame(30, 8'h60, 1'b0);
    while (!tx_collision) @(negedge clk_sys);
    kill = 2'd0;
    tx_frame(20, 8'h70, 1'b1);
    drain();
    cmp("abort");
    ack_dly = 4'hf;
    for (int f = 0; f < 4; f++) tx_frame(1000, 8'(f), 1'b1);
    fork
      tx_frame(200, 8'h80, 1'b1);
    join_none
    while (!tx_usr_dst_rdy_n) @(negedge clk_sys);
    chk(tx_fifo_status, 4'hf);
    ack_dly = 4'h2;
    wait fork;
    drain();
    cmp("tx full");
    tx_frame(4200, 8'h90, 1'b0);
    chk(txo, 1'b1);
    tx_frame(20, 8'ha0, 1'b1);
    drain();
    cmp("tx overflow");
    test_done();
  end
endmodule
`default_nettype wire
